// ---- sdr_pkg.sv ----
// constants and types shared by the shift and digit rotate unit
package sdr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_GPR_BASE = 8'h00;
  localparam logic [7:0] OFF_IDX_FIRST = 8'h20;
  localparam logic [7:0] OFF_IDX_SECOND = 8'h24;
  localparam logic [7:0] OFF_OPBYTE = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_GPR_LAST = 8'h1C;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_DECODING = 2;
  localparam logic [7:0] GPR_RST = 8'h00;
  localparam logic [15:0] IDX_RST = 16'h0000;

  // ----------------------------------------------------------------
  // flag byte layout and register codes
  // ----------------------------------------------------------------
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_H = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N = 1;
  localparam int FLG_C = 0;
  localparam logic [2:0] CODE_MEM = 3'h6;
  localparam logic [2:0] CODE_ACC = 3'h7;
  localparam logic [2:0] CODE_FLAGS = 3'h6;
  localparam logic [2:0] CODE_PTR_HI = 3'h4;
  localparam logic [2:0] CODE_PTR_LO = 3'h5;

  // ----------------------------------------------------------------
  // opcode bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] PFX_SHIFT = 8'hCB;
  localparam logic [7:0] PFX_IDX_FIRST = 8'hDD;
  localparam logic [7:0] PFX_IDX_SECOND = 8'hFD;
  localparam logic [7:0] PFX_EXT = 8'hED;
  localparam logic [7:0] OPC_DIGIT_ROT = 8'h6F;
  localparam logic [7:0] OPC_ASL_MEM = 8'h26;
  localparam logic [7:0] OPC_ASR_MEM = 8'h2E;
  localparam logic [7:0] OPC_LSR_MEM = 8'h3E;

  // ----------------------------------------------------------------
  // timing, one T state per clock cycle at 100 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_STATE_NS = 10;
  localparam int CYC_PER_T = T_STATE_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CYC_REG = 8'(8 * CYC_PER_T);
  localparam logic [7:0] CYC_PTR = 8'(15 * CYC_PER_T);
  localparam logic [7:0] CYC_IDX = 8'(23 * CYC_PER_T);
  localparam logic [7:0] CYC_DIG = 8'(18 * CYC_PER_T);
  localparam logic [7:0] RD_PTR_FIRST = 8'(8 * CYC_PER_T);
  localparam logic [7:0] RD_PTR_LAST = 8'(12 * CYC_PER_T - 1);
  localparam logic [7:0] RD_IDX_FIRST = 8'(16 * CYC_PER_T);
  localparam logic [7:0] RD_IDX_LAST = 8'(20 * CYC_PER_T - 1);
  localparam logic [7:0] RD_DIG_FIRST = 8'(8 * CYC_PER_T);
  localparam logic [7:0] RD_DIG_LAST = 8'(11 * CYC_PER_T - 1);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDR_ASL,
    SDR_ASR,
    SDR_LSR,
    SDR_DROT
  } sdr_op_t;

  typedef enum logic [1:0] {
    MODE_REG,
    MODE_PTR,
    MODE_IDX,
    MODE_DIG
  } sdr_mode_t;

  typedef enum logic [2:0] {
    DEC_IDLE,
    DEC_SHIFT,
    DEC_IDX,
    DEC_IDX_SHIFT,
    DEC_IDX_OP,
    DEC_EXT
  } sdr_dec_t;

endpackage : sdr_pkg

// ---- sdr_alu_if.sv ----
// operand and result bundle between core and alu
`timescale 1ns/1ps
`default_nettype none
interface sdr_alu_if;
  import sdr_pkg::*;
  sdr_op_t op;
  logic [7:0] opnd;
  logic [7:0] acc;
  logic [7:0] f_in;
  logic [7:0] res;
  logic [7:0] acc_res;
  logic [7:0] f_res;
  modport core (output op, output opnd, output acc, output f_in, input res, input acc_res, input f_res);
  modport alu (input op, input opnd, input acc, input f_in, output res, output acc_res, output f_res);
endinterface : sdr_alu_if
`default_nettype wire

// ---- sdr_alu.sv ----
// shift and digit rotate result and flag logic
`timescale 1ns/1ps
`default_nettype none
module sdr_alu (
  sdr_alu_if.alu a
);
  import sdr_pkg::*;

  logic [7:0] res;
  logic [7:0] acc_n;
  logic c_n;
  wire [7:0] flag_src;

  always_comb
  begin
    res = a.opnd;
    acc_n = a.acc;
    c_n = a.f_in[FLG_C];
    case (a.op)
      SDR_ASL:
      begin
        res = {a.opnd[6:0], 1'b0};
        c_n = a.opnd[7];
      end
      SDR_ASR:
      begin
        res = {a.opnd[7], a.opnd[7:1]};
        c_n = a.opnd[0];
      end
      SDR_LSR:
      begin
        res = {1'b0, a.opnd[7:1]};
        c_n = a.opnd[0];
      end
      SDR_DROT:
      begin
        res = {a.opnd[3:0], a.acc[3:0]};
        acc_n = {a.acc[7:4], a.opnd[7:4]};
      end
      default:
      begin
        res = a.opnd;
      end
    endcase
  end

  // digit rotate flags follow the accumulator, shifts the result
  assign flag_src = (a.op == SDR_DROT) ? acc_n : res;

  assign a.res = res;
  assign a.acc_res = acc_n;
  assign a.f_res = {flag_src[7],
                    (flag_src == 8'h00),
                    a.f_in[5],
                    1'b0,
                    a.f_in[3],
                    ~^flag_src,
                    1'b0,
                    c_n};

endmodule : sdr_alu
`default_nettype wire

// ---- sdr_top.sv ----
// shift and digit rotate unit: apb registers, opcode decode, memory sequencing
// What this block does
// - left shift, old bit 7 into carry
// - arithmetic right shift keeps bit 7
// - logical right shift clears bit 7, sign
// - sign follows result bit 7
// - zero flag when result is zero
// - parity even sets flag; half, subtract cleared
// - register codes 000-101 general, 111 accumulator
// - register, pointer pair, two indexed forms
// - prefix CB; indexed DD/FD, CB, displacement, op
// - memory op bytes 26, 2E, 3E
// - 8, 15, 23 states per form
// - digit rotate moves nibbles through accumulator
// - accumulator high nibble kept
// - digit rotate sign, zero; carry kept
// - digit rotate parity; half, subtract cleared
// - ED 6F addresses byte via pointer pair
`timescale 1ns/1ps
`default_nettype none
module sdr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic busy
);
  import sdr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] gpr_q [0:7];
  logic [15:0] idx_first_q;
  logic [15:0] idx_second_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic busy_q;
  sdr_dec_t dec_q;
  sdr_dec_t dec_d;
  logic idx_sel_q;
  logic [7:0] disp_q;
  sdr_op_t op_q;
  sdr_mode_t mode_q;
  logic [2:0] code_q;
  logic [7:0] t_q;
  logic [7:0] opnd_q;
  logic [15:0] mem_addr_q;
  logic mem_rd_q;
  logic mem_wr_q;
  logic [7:0] mem_wdata_q;
  logic [7:0] rdata_s1_q;
  logic [7:0] rdata_s2_q;

  sdr_alu_if alu_bus ();

  sdr_alu u_alu (
    .a (alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup_acc = psel & penable & ~pready_q;
  wire done_acc = psel & penable & pready_q;
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_gpr = aligned & (paddr <= OFF_GPR_LAST);
  wire hit_idx0 = (paddr == OFF_IDX_FIRST);
  wire hit_idx1 = (paddr == OFF_IDX_SECOND);
  wire hit_op = (paddr == OFF_OPBYTE);
  wire hit_stat = (paddr == OFF_STATUS);
  wire mapped = hit_gpr | hit_idx0 | hit_idx1 | hit_op | hit_stat;
  wire [2:0] gpr_sel = paddr[4:2];
  // register, index and opcode writes are refused while an instruction runs; status writes are still accepted
  wire busy_refuse = pwrite & busy_q & (hit_gpr | hit_idx0 | hit_idx1 | hit_op);
  wire err_d = ~mapped | busy_refuse;
  // refused transfers never reach a register
  wire wr_ok = done_acc & pwrite & ~pslverr_q;
  logic [7:0] status_rd;
  always_comb
  begin
    status_rd = 8'h00;
    status_rd[STAT_BUSY] = busy_q;
    status_rd[STAT_ERR] = err_q;
    status_rd[STAT_DECODING] = (dec_q != DEC_IDLE);
  end
  wire [31:0] rd_mux = hit_gpr ? {24'h000000, gpr_q[gpr_sel]} :
                       hit_idx0 ? {16'h0000, idx_first_q} :
                       hit_idx1 ? {16'h0000, idx_second_q} :
                       hit_stat ? {24'h000000, status_rd} : 32'h00000000;

  // ----------------------------------------------------------------
  // opcode byte decode
  // ----------------------------------------------------------------
  wire [7:0] ob = pwdata[7:0];
  wire ob_feed = wr_ok & hit_op;
  wire [4:0] ob_grp = ob[7:3];
  wire grp_asl = (ob_grp == OPC_ASL_MEM[7:3]);
  wire grp_asr = (ob_grp == OPC_ASR_MEM[7:3]);
  wire grp_lsr = (ob_grp == OPC_LSR_MEM[7:3]);
  wire grp_ok = grp_asl | grp_asr | grp_lsr;
  // code 110 selects memory; every other code a register in the CB form, refused in the indexed form
  wire ob_mem = (ob[2:0] == CODE_MEM);
  wire ob_digit = (ob == OPC_DIGIT_ROT);
  wire sdr_op_t ob_op = grp_asl ? SDR_ASL : (grp_asr ? SDR_ASR : SDR_LSR);
  wire start_shift = ob_feed & (dec_q == DEC_SHIFT) & grp_ok;
  wire start_idx = ob_feed & (dec_q == DEC_IDX_OP) & grp_ok & ob_mem;
  wire start_dig = ob_feed & (dec_q == DEC_EXT) & ob_digit;
  wire start = start_shift | start_idx | start_dig;
  wire dec_known = (ob == PFX_SHIFT) | (ob == PFX_IDX_FIRST) | (ob == PFX_IDX_SECOND) | (ob == PFX_EXT);
  wire bad_byte = ob_feed & (dec_d == DEC_IDLE) & ~start & (dec_q != DEC_IDLE | ~dec_known);

  always_comb
  begin
    dec_d = dec_q;
    if (ob_feed)
    begin
      case (dec_q)
        DEC_IDLE:
        begin
          if (ob == PFX_SHIFT)
            dec_d = DEC_SHIFT;
          else if ((ob == PFX_IDX_FIRST) | (ob == PFX_IDX_SECOND))
            dec_d = DEC_IDX;
          else if (ob == PFX_EXT)
            dec_d = DEC_EXT;
          else
            dec_d = DEC_IDLE;
        end
        DEC_IDX:
        begin
          dec_d = (ob == PFX_SHIFT) ? DEC_IDX_SHIFT : DEC_IDLE;
        end
        DEC_IDX_SHIFT:
        begin
          dec_d = DEC_IDX_OP;
        end
        DEC_SHIFT, DEC_IDX_OP, DEC_EXT:
        begin
          dec_d = DEC_IDLE;
        end
        default:
        begin
          dec_d = DEC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // operand address and cycle profile
  // ----------------------------------------------------------------
  wire [15:0] ptr_pair = {gpr_q[CODE_PTR_HI], gpr_q[CODE_PTR_LO]};
  wire [15:0] idx_base = idx_sel_q ? idx_second_q : idx_first_q;
  wire [15:0] idx_addr = idx_base + {{8{disp_q[7]}}, disp_q};
  wire sdr_mode_t mode_d = start_dig ? MODE_DIG :
                           (start_idx ? MODE_IDX : (ob_mem ? MODE_PTR : MODE_REG));
  wire [7:0] cyc_total = (mode_q == MODE_REG) ? CYC_REG :
                         (mode_q == MODE_PTR) ? CYC_PTR :
                         (mode_q == MODE_IDX) ? CYC_IDX : CYC_DIG;
  wire [7:0] rd_first = (mode_q == MODE_PTR) ? RD_PTR_FIRST :
                        (mode_q == MODE_IDX) ? RD_IDX_FIRST : RD_DIG_FIRST;
  wire [7:0] rd_last = (mode_q == MODE_PTR) ? RD_PTR_LAST :
                       (mode_q == MODE_IDX) ? RD_IDX_LAST : RD_DIG_LAST;
  wire is_mem = (mode_q != MODE_REG);
  wire t_end = busy_q & (t_q == cyc_total - 8'h01);
  // read strobe registered, so it is raised one count early
  wire rd_on = busy_q & is_mem & (t_q >= rd_first - 8'h01) & (t_q < rd_last);
  // pin data is two flops late; sampled once it has settled
  wire rd_capture = busy_q & is_mem & (t_q == rd_last + 8'h01);
  wire wr_on = busy_q & is_mem & (t_q == cyc_total - 8'h02);

  assign alu_bus.op = op_q;
  assign alu_bus.opnd = opnd_q;
  assign alu_bus.acc = gpr_q[CODE_ACC];
  assign alu_bus.f_in = gpr_q[CODE_FLAGS];

  // ----------------------------------------------------------------
  // apb slave response
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_q <= setup_acc;
      if (setup_acc)
      begin
        pslverr_q <= err_d;
        prdata_q <= (pwrite | err_d) ? 32'h00000000 : rd_mux;
      end
      else if (done_acc)
      begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // decode and sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_q <= DEC_IDLE;
      idx_sel_q <= 1'b0;
      disp_q <= 8'h00;
      op_q <= SDR_ASL;
      mode_q <= MODE_REG;
      code_q <= 3'h0;
      busy_q <= 1'b0;
      t_q <= 8'h00;
      err_q <= 1'b0;
    end
    else if (ce)
    begin
      dec_q <= dec_d;
      if (ob_feed & (dec_q == DEC_IDLE))
        idx_sel_q <= (ob == PFX_IDX_SECOND);
      if (ob_feed & (dec_q == DEC_IDX_SHIFT))
        disp_q <= ob;
      // new error wins over a clear in the same cycle
      if (bad_byte)
        err_q <= 1'b1;
      else if (wr_ok & hit_stat & pwdata[STAT_ERR])
        err_q <= 1'b0;
      if (start)
      begin
        busy_q <= 1'b1;
        t_q <= 8'h00;
        op_q <= start_dig ? SDR_DROT : ob_op;
        mode_q <= mode_d;
        code_q <= ob[2:0];
      end
      else if (t_end)
      begin
        busy_q <= 1'b0;
      end
      else if (busy_q)
      begin
        t_q <= t_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file and memory port
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        gpr_q[i] <= GPR_RST;
      idx_first_q <= IDX_RST;
      idx_second_q <= IDX_RST;
      opnd_q <= 8'h00;
      mem_addr_q <= 16'h0000;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_ok & hit_gpr)
        gpr_q[gpr_sel] <= pwdata[7:0];
      if (wr_ok & hit_idx0)
        idx_first_q <= pwdata[15:0];
      if (wr_ok & hit_idx1)
        idx_second_q <= pwdata[15:0];
      if (start)
      begin
        opnd_q <= gpr_q[ob[2:0]];
        mem_addr_q <= start_idx ? idx_addr : ptr_pair;
      end
      else if (rd_capture)
      begin
        opnd_q <= rdata_s2_q;
      end
      mem_rd_q <= rd_on;
      mem_wr_q <= wr_on;
      mem_wdata_q <= alu_bus.res;
      if (t_end)
      begin
        gpr_q[CODE_FLAGS] <= alu_bus.f_res;
        if (mode_q == MODE_REG)
          gpr_q[code_q] <= alu_bus.res;
        if (mode_q == MODE_DIG)
          gpr_q[CODE_ACC] <= alu_bus.acc_res;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_s1_q <= 8'h00;
      rdata_s2_q <= 8'h00;
    end
    else if (ce)
    begin
      rdata_s1_q <= mem_rdata;
      rdata_s2_q <= rdata_s1_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_addr = mem_addr_q;
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign mem_wdata = mem_wdata_q;
  assign busy = busy_q;

endmodule : sdr_top
`default_nettype wire

// ---- sdr_props.sv ----
// port assertions for the shift and digit rotate unit
`timescale 1ns/1ps
`default_nettype none
module sdr_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic busy
);
  // ----------------------------------------
  // busy length counter
  // ----------------------------------------
  logic [7:0] run_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run_q <= 8'h00;
    else if (ce)
      run_q <= busy ? run_q + 8'h01 : 8'h00;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_read;
    mem_rd [*3];
  endsequence
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence

  chk_busy_len:
    assert property ($fell(busy) |-> run_q inside {8'h08, 8'h0F, 8'h12, 8'h17}) else $error("busy length wrong");
  chk_wr_in_busy:
    assert property (mem_wr |-> busy && !mem_rd) else $error("write outside instruction");
  chk_wr_pulse:
    assert property (mem_wr |=> !mem_wr) else $error("write strobe too long");
  chk_rd_window:
    assert property ($rose(mem_rd) |-> s_read ##[1:2] !mem_rd) else $error("read window length wrong");
  chk_rd_then_wr:
    assert property ($rose(mem_rd) |-> ##[5:9] mem_wr) else $error("no write back after read");
  chk_addr_held:
    assert property (busy && $past(busy) |-> $stable(mem_addr)) else $error("operand address moved");
  chk_idle_quiet:
    assert property (!busy |-> !mem_rd && !mem_wr) else $error("memory strobe while idle");
  chk_apb_wait:
    assert property (s_access |-> !pready ##1 pready) else $error("apb wait state wrong");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held too long");
  chk_err_zero:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("error without zero data");
endmodule : sdr_props
bind sdr_top sdr_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .busy(busy));
`default_nettype wire

// ---- sdr_mem_model.sv ----
// byte memory answering the unit's read and write strobes
`timescale 1ns/1ps
`default_nettype none
module sdr_mem_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] store [0:65535];
  logic [7:0] junk_q = 8'h5A;
  logic rd_q = 1'h0;
  // slow mode: data only from second read cycle, junk otherwise
  assign mem_rdata = (mem_rd && (!slow || rd_q)) ? store[mem_addr] : junk_q;
  // plain always: the bench also preloads store
  always @(posedge pclk)
  begin
    junk_q <= ~junk_q + 8'h01;
    rd_q <= mem_rd;
    if (mem_wr)
      store[mem_addr] <= mem_wdata;
  end
endmodule : sdr_mem_model
`default_nettype wire

// ---- tb_shift_and_digit_rotate_unit.sv ----
// self-checking bench for the shift and digit rotate unit
`timescale 1ns/1ps
`default_nettype none
module tb_shift_and_digit_rotate_unit;
  import sdr_pkg::*;
  typedef struct {logic [7:0] pfx; logic [7:0] disp; logic [7:0] opb; logic [7:0] val;} sdr_row_t;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr, busy, slow, err;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [15:0] mem_addr, ad;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ex;
  int mismatches, checks, n;
  sdr_row_t r;
  sdr_row_t rows [10] = '{'{8'hCB, 8'h00, 8'h25, 8'hB1}, '{8'hCB, 8'h00, 8'h28, 8'hB8},
    '{8'hCB, 8'h00, 8'h39, 8'h8F}, '{8'hCB, 8'h00, 8'h22, 8'h80}, '{8'hCB, 8'h00, 8'h2B, 8'h01},
    '{8'hCB, 8'h00, 8'h3C, 8'h01}, '{8'hCB, 8'h00, 8'h2F, 8'h81}, '{8'hCB, 8'h00, 8'h26, 8'h81},
    '{8'hDD, 8'h03, 8'h2E, 8'hB8}, '{8'hFD, 8'hFE, 8'h3E, 8'h00}};

  sdr_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy));
  sdr_mem_model u_mem (.pclk(pclk), .slow(slow), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic run();
    int k;
    k = 0;
    n = 0;
    while (busy !== 1'h1 && k < 10)
    begin
      @(posedge pclk);
      k++;
    end
    while (busy === 1'h1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : run

  function automatic logic [15:0] calc(input logic [7:0] opb, input logic [7:0] v, input logic [7:0] fin);
    logic [7:0] s;
    logic c;
    s = (opb[5:3] == 3'h4) ? {v[6:0], 1'h0} : {(opb[5:3] == 3'h5) & v[7], v[7:1]};
    c = (opb[5:3] == 3'h4) ? v[7] : v[0];
    return {s, s[7], s == 8'h00, fin[5], 1'h0, fin[3], ~^s, 1'h0, c};
  endfunction : calc

  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, slow} = 5'h00;
    ce = 1'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0, "status after reset");
    apb(1'h1, OFF_IDX_FIRST, 32'h1000);
    apb(1'h1, OFF_IDX_SECOND, 32'h2000);
    foreach (rows[i])
    begin
      r = rows[i];
      slow <= i[0];
      apb(1'h1, 8'h10, 32'h12);
      apb(1'h1, 8'h14, 32'h34);
      apb(1'h1, 8'h18, 32'hFF);
      ad = ((r.pfx == PFX_IDX_FIRST) ? 16'h1000 : 16'h2000) + {{8{r.disp[7]}}, r.disp};
      if (r.pfx == PFX_SHIFT)
        ad = 16'h1234;
      if (r.opb[2:0] == CODE_MEM)
        u_mem.store[ad] = r.val;
      else
        apb(1'h1, {3'h0, r.opb[2:0], 2'h0}, {24'h0, r.val});
      if (r.pfx != PFX_SHIFT)
        apb(1'h1, OFF_OPBYTE, {24'h0, r.pfx});
      apb(1'h1, OFF_OPBYTE, {24'h0, PFX_SHIFT});
      if (r.pfx != PFX_SHIFT)
        apb(1'h1, OFF_OPBYTE, {24'h0, r.disp});
      apb(1'h1, OFF_OPBYTE, {24'h0, r.opb});
      run();
      ex = calc(r.opb, r.val, 8'hFF);
      cmp(n, (r.pfx != PFX_SHIFT) ? CYC_IDX : (r.opb[2:0] == CODE_MEM) ? CYC_PTR : CYC_REG, "cycles");
      if (r.opb[2:0] == CODE_MEM)
        cmp(u_mem.store[ad], ex[15:8], "memory result");
      else
        apb(1'h0, {3'h0, r.opb[2:0], 2'h0}, 32'h0);
      if (r.opb[2:0] != CODE_MEM)
        cmp(rd, ex[15:8], "register result");
      apb(1'h0, 8'h18, 32'h0);
      cmp(rd, ex[7:0], "flags");
      $display("row %0d done", i);
    end
    apb(1'h1, 8'h1C, 32'h7A);
    apb(1'h1, 8'h18, 32'h01);
    apb(1'h1, 8'h10, 32'h50);
    apb(1'h1, 8'h14, 32'h00);
    u_mem.store[16'h5000] = 8'h31;
    apb(1'h1, OFF_OPBYTE, {24'h0, PFX_EXT});
    apb(1'h1, OFF_OPBYTE, {24'h0, OPC_DIGIT_ROT});
    run();
    cmp(n, CYC_DIG, "digit cycles");
    cmp(u_mem.store[16'h5000], 8'h1A, "digit memory");
    apb(1'h0, 8'h1C, 32'h0);
    cmp(rd, 8'h73, "digit accumulator");
    apb(1'h0, 8'h18, 32'h0);
    cmp(rd, 8'h01, "digit flags");
    $display("digit rotate done");
    apb(1'h1, 8'h00, 32'h40);
    apb(1'h1, OFF_OPBYTE, {24'h0, PFX_SHIFT});
    apb(1'h1, OFF_OPBYTE, 32'h20);
    apb(1'h1, 8'h00, 32'h55);
    cmp(err, 1'h1, "write while busy");
    run();
    apb(1'h0, 8'h00, 32'h0);
    cmp(rd, 32'h80, "refused write ignored");
    apb(1'h1, OFF_OPBYTE, {24'h0, PFX_EXT});
    apb(1'h1, OFF_OPBYTE, 32'h00);
    apb(1'h0, OFF_STATUS, 32'h0);
    cmp(rd[2:0], 3'h2, "bad sequence status");
    apb(1'h1, OFF_STATUS, 32'h2);
    apb(1'h0, OFF_STATUS, 32'h0);
    cmp(rd[2:0], 3'h0, "error cleared");
    apb(1'h1, OFF_OPBYTE, {24'h0, PFX_SHIFT});
    apb(1'h1, OFF_OPBYTE, 32'h06);
    apb(1'h0, OFF_STATUS, 32'h0);
    cmp(rd[2:0], 3'h2, "unsupported op refused");
    apb(1'h0, 8'h30, 32'h0);
    cmp(err, 1'h1, "unmapped error");
    cmp(rd, 32'h0, "unmapped read");
    $display("refusals done");
    apb(1'h1, OFF_OPBYTE, {24'h0, PFX_SHIFT});
    apb(1'h1, OFF_OPBYTE, 32'h20);
    fork
      run();
      begin
        repeat (3) @(posedge pclk);
        ce <= 1'h0;
        repeat (4) @(posedge pclk);
        ce <= 1'h1;
      end
    join
    cmp(n, CYC_REG + 4, "frozen cycles");
    $display("clock enable done");
    apb(1'h1, OFF_OPBYTE, {24'h0, PFX_SHIFT});
    apb(1'h1, OFF_OPBYTE, 32'h20);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0, "status after mid-run reset");
    apb(1'h0, 8'h1C, 32'h0);
    cmp(rd, 32'h0, "accumulator after reset");
    $display("mid-run reset done");
    end_sim();
  end
endmodule : tb_shift_and_digit_rotate_unit
`default_nettype wire
